// ---- hdl/ssdu_top.sv ----
// Self-supervision and diagnostic unit: watchdog, alarm groups, status words, Wishbone slave
// Contract
// - Watchdog supervises and restarts stuck controller
// - Failed restart flags permanent internal fault
// - Permanent fault blocks all other outputs (here only dout_o and the service output are blocked)
// - Service output needs supply and full operation
// - Provide link, port, group and password alarms
// - Each source assignable to one group
// - Per-group service link, reset links group two
// - Each group alarm routable on its own
// - Boot and runtime self-tests are checked
// - Permanent state drops output, lights indicator
// - Loss of main functions means permanent state (here only once a restart fails to restore them)
// - Temporary fault sets signal, event 56
// - Temporary fault clearing gives event 57
// - Front panel reset clears latched state
// - Four 16-bit readable diagnostic words
// - Word one: outputs bits 2-15, 0-1 reserved
// - Word two bits 0-14 further outputs
// - Word four bits 0-9 system faults
// - Bit codes reported with events and menu
`timescale 1ns/100ps

module ssdu_top
  import ssdu_pkg::*;
#(
  parameter int unsigned WDT_CYCLES     = ssdu_pkg::WDT_TIMEOUT_CYC,  // Heartbeat timeout
  parameter int unsigned RESTART_CYCLES = ssdu_pkg::RESTART_PULSE_CYC // Restart pulse length
) (
  input  wire logic                           clk_i,            // 50 MHz clock
  input  wire logic                           rst_i,            // Synchronous reset
  // Wishbone classic slave
  input  wire logic                           wb_cyc_i,
  input  wire logic                           wb_stb_i,
  input  wire logic                           wb_we_i,
  input  wire logic [7:0]                     wb_adr_i,
  input  wire logic [3:0]                     wb_sel_i,
  input  wire logic [31:0]                    wb_dat_i,
  output logic      [31:0]                    wb_dat_o,
  output logic                                wb_ack_o,
  // Supervised controller
  input  wire logic                           heartbeat_i,      // Toggles while program runs
  output logic                                mcu_restart_o,    // Restart request to controller
  // Supply and self-test inputs (pins)
  input  wire logic                           aux_supply_ok_i,  // Auxiliary supply present
  input  wire logic                           rails_ok_i,       // Internal rails in range
  input  wire logic                           boot_test_ok_i,   // Boot self-test passed
  input  wire logic                           main_func_ok_i,   // Main functions running
  input  wire logic                           temp_fault_i,     // Temporary inoperative
  input  wire logic                           panel_reset_i,    // Front panel reset
  // Alarm sources and fault inputs
  input  wire logic [ssdu_pkg::NUM_SRC-1:0]   alarm_src_i,      // Self-supervision sources
  input  wire logic [ssdu_pkg::NUM_DOUT-1:0]  dout_fault_i,     // Digital output faults
  input  wire logic [ssdu_pkg::NUM_AUXOUT-1:0] auxout_fault_i,  // Further output faults
  input  wire logic [ssdu_pkg::NUM_SYS-1:0]   sys_fault_i,      // Word-four system faults
  input  wire logic                           remote_link_up_i, // Remote link active
  input  wire logic                           ext_io_link_up_i, // Extension I/O link active
  input  wire logic                           port_one_up_i,
  input  wire logic                           port_two_up_i,
  input  wire logic                           password_open_i,
  // Output side
  input  wire logic [ssdu_pkg::NUM_DOUT-1:0]  dout_req_i,       // Requested output states
  output logic      [ssdu_pkg::NUM_DOUT-1:0]  dout_o,           // Gated digital outputs
  output logic                                service_fail_output_o,
  output logic                                status_led_o,
  output logic                                panel_fault_msg_o,
  output logic      [2:0]                     diag_group_o,     // Group alarms to matrix
  output logic                                diag_matrix_sig_o,
  output logic                                remote_link_alarm_o,
  output logic                                ext_io_link_alarm_o,
  output logic                                port_one_alarm_o,
  output logic                                port_two_alarm_o,
  output logic                                password_open_alarm_o,
  output logic                                event_valid_o,    // One-cycle event pulse
  output logic      [7:0]                     event_code_o
);

  // ====================
  // Input synchronisers
  // ====================
  localparam int unsigned SW = 10 + NUM_SRC + NUM_DOUT + NUM_AUXOUT + NUM_SYS;

  logic [SW-1:0] raw_in;     // Pin inputs except port two, password and output requests
  logic [SW-1:0] sync1_q;    // First stage, read only by second stage
  logic [SW-1:0] sync2_q;    // Safe to use

  assign raw_in = {heartbeat_i, aux_supply_ok_i, rails_ok_i, boot_test_ok_i, main_func_ok_i,
                   temp_fault_i, panel_reset_i, remote_link_up_i, ext_io_link_up_i,
                   port_one_up_i,
                   alarm_src_i, dout_fault_i, auxout_fault_i, sys_fault_i};

  // Two-stage synchroniser for every raw_in pin; password_open_i and dout_req_i are not synchronised
  always_ff @(posedge clk_i) begin
    sync1_q <= raw_in;
    sync2_q <= sync1_q;
  end

  logic                   port_two_s;   // Port two has its own pair
  logic                   port_two_m_q;
  always_ff @(posedge clk_i) begin
    port_two_m_q <= port_two_up_i;
    port_two_s   <= port_two_m_q;
  end

  // Unpacked synchronised signals
  logic                   hb_s, aux_s, rails_s, boot_s, main_s, temp_s, panel_s;
  logic                   remote_s, extio_s, port_one_s;
  logic [NUM_SRC-1:0]     src_s;
  logic [NUM_DOUT-1:0]    dflt_s;
  logic [NUM_AUXOUT-1:0]  aflt_s;
  logic [NUM_SYS-1:0]     sys_s;
  assign {hb_s, aux_s, rails_s, boot_s, main_s, temp_s, panel_s, remote_s, extio_s,
          port_one_s, src_s, dflt_s, aflt_s, sys_s} = sync2_q;

  // ====================
  // Register bus state
  // ====================
  logic [2:0]          link_q;      // Group links to service output
  logic [31:0]         grp_sel_q;   // Two bits per source
  logic                clear_req;   // Software clear pulse
  logic                wb_req;      // Valid new request
  logic                wb_wr;

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr  = wb_req && wb_we_i;

  // Control writes; diagnostic words take no writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_q    <= LINK_RESET;
      grp_sel_q <= GRP_SEL_RESET;
    end else if (wb_wr) begin
      if (wb_adr_i == OFF_CTRL && wb_sel_i[0]) begin
        link_q <= wb_dat_i[CTRL_LINK_LSB +: 3];
      end
      if (wb_adr_i == OFF_GRP_SEL) begin
        for (int b = 0; b < 4; b++) begin
          if (wb_sel_i[b]) begin
            grp_sel_q[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
          end
        end
      end
    end
  end

  assign clear_req = wb_wr && wb_adr_i == OFF_CTRL && wb_sel_i[1] && wb_dat_i[CTRL_CLEAR];

  // ====================
  // Watchdog
  // ====================
  ssdu_wdt_t           wdt_q;
  logic [CNT_W-1:0]    wdt_cnt_q;   // Cycles since last heartbeat edge
  logic [7:0]          restarts_q;  // Restarts attempted
  logic                hb_prev_q;
  logic                hb_edge;
  logic                inoperable;

  assign hb_edge    = hb_s ^ hb_prev_q;
  // Missed heartbeat, lost main function or failed boot test counts as inoperable
  assign inoperable = (wdt_cnt_q >= CNT_W'(WDT_CYCLES)) || !main_s || !boot_s;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hb_prev_q <= 1'b0;
    end else begin
      hb_prev_q <= hb_s;
    end
  end

  // Supervision sequence; permanent state holds until reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdt_q      <= SSDU_RUN;
      wdt_cnt_q  <= '0;
      restarts_q <= 8'h00;
    end else begin
      unique case (wdt_q)
        SSDU_RUN: begin
          if (inoperable) begin
            wdt_cnt_q <= '0;
            if (restarts_q >= 8'(MAX_RESTARTS)) begin
              wdt_q <= SSDU_PERM;
            end else begin
              wdt_q      <= SSDU_RESTART;
              restarts_q <= restarts_q + 8'h01;
            end
          end else if (hb_edge) begin
            wdt_cnt_q <= '0;
          end else begin
            wdt_cnt_q <= wdt_cnt_q + 1'b1;
          end
        end
        SSDU_RESTART: begin
          // Hold restart for its pulse length
          if (wdt_cnt_q >= CNT_W'(RESTART_CYCLES) - 1'b1) begin
            wdt_q     <= SSDU_WAIT;
            wdt_cnt_q <= '0;
          end else begin
            wdt_cnt_q <= wdt_cnt_q + 1'b1;
          end
        end
        SSDU_WAIT: begin
          // Controller must show a heartbeat within the timeout
          if (hb_edge && main_s && boot_s) begin
            wdt_q      <= SSDU_RUN;
            wdt_cnt_q  <= '0;
            restarts_q <= 8'h00;  // Recovered, restart budget renewed
          end else if (wdt_cnt_q >= CNT_W'(WDT_CYCLES)) begin
            wdt_q <= SSDU_PERM;
          end else begin
            wdt_cnt_q <= wdt_cnt_q + 1'b1;
          end
        end
        SSDU_PERM: begin
          wdt_q <= SSDU_PERM;  // Only reset leaves it
        end
      endcase
    end
  end

  logic perm;
  assign perm = (wdt_q == SSDU_PERM);

  // ====================
  // Alarm groups
  // ====================
  logic [2:0] grp_alarm;

  // Group alarm is OR of its assigned sources
  genvar g;
  generate
    for (g = 0; g < NUM_GROUPS; g++) begin : gen_grp
      logic [NUM_SRC-1:0] hit;
      for (genvar s = 0; s < NUM_SRC; s++) begin : gen_src
        assign hit[s] = src_s[s] && (grp_sel_q[2*s +: 2] == 2'(g + 1));
      end
      assign grp_alarm[g] = |hit;
    end
  endgenerate

  // ====================
  // Temporary state, events and latched diagnostics
  // ====================
  logic       temp_prev_q;
  logic       temp_latch_q;   // Latched diagnostic state
  logic [7:0] last_evt_q;

  // Edge events on temporary inoperative state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      temp_prev_q   <= 1'b0;
      event_valid_o <= 1'b0;
      event_code_o  <= 8'h00;
      last_evt_q    <= 8'h00;
    end else begin
      temp_prev_q   <= temp_s;
      event_valid_o <= temp_s ^ temp_prev_q;
      if (temp_s && !temp_prev_q) begin
        event_code_o <= EVT_TEMP_ON;
        last_evt_q   <= EVT_TEMP_ON;
      end else if (!temp_s && temp_prev_q) begin
        event_code_o <= EVT_TEMP_OFF;
        last_evt_q   <= EVT_TEMP_OFF;
      end
    end
  end

  // Latched state; an active temporary fault wins over a clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      temp_latch_q <= 1'b0;
    end else if (temp_s) begin
      temp_latch_q <= 1'b1;
    end else if (panel_s || clear_req) begin
      temp_latch_q <= 1'b0;
    end
  end

  // ====================
  // Outputs
  // ====================
  logic svc_ok;
  // Energised only when supplied, healthy and no linked group active
  assign svc_ok = aux_s && rails_s && boot_s && !perm && !(|(grp_alarm & link_q));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      service_fail_output_o <= 1'b0;
      status_led_o          <= 1'b0;
      panel_fault_msg_o     <= 1'b0;
      mcu_restart_o         <= 1'b0;
      dout_o                <= '0;
      diag_group_o          <= 3'h0;
      diag_matrix_sig_o     <= 1'b0;
    end else begin
      service_fail_output_o <= svc_ok;
      status_led_o          <= perm;
      panel_fault_msg_o     <= perm;
      mcu_restart_o         <= (wdt_q == SSDU_RESTART);
      dout_o                <= perm ? '0 : dout_req_i;
      diag_group_o          <= grp_alarm;
      diag_matrix_sig_o     <= temp_latch_q || temp_s;
    end
  end

  // Link, port and password alarms for the output matrix
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      remote_link_alarm_o   <= 1'b0;
      ext_io_link_alarm_o   <= 1'b0;
      port_one_alarm_o      <= 1'b0;
      port_two_alarm_o      <= 1'b0;
      password_open_alarm_o <= 1'b0;
    end else begin
      remote_link_alarm_o   <= !remote_s;
      ext_io_link_alarm_o   <= !extio_s;
      port_one_alarm_o      <= !port_one_s;
      port_two_alarm_o      <= !port_two_s;
      password_open_alarm_o <= password_open_i;
    end
  end

  // ====================
  // Diagnostic words and read path
  // ====================
  logic [DIAG_W-1:0] word_one, word_two, word_four;

  // Live fault state, not latched
  assign word_one  = {dflt_s[8], aflt_s, dflt_s[7:0], 2'b00};
  assign word_two  = {1'b0, dflt_s[23:9]};
  assign word_four = {6'h00, sys_s};

  // Single-cycle acknowledge; unmapped addresses read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        unique case (wb_adr_i)
          OFF_DIAG_ONE:   wb_dat_o <= {16'h0000, word_one};
          OFF_DIAG_TWO:   wb_dat_o <= {16'h0000, word_two};
          OFF_DIAG_THREE: wb_dat_o <= 32'h0000_0000;
          OFF_DIAG_FOUR:  wb_dat_o <= {16'h0000, word_four};
          OFF_CTRL:       wb_dat_o <= {29'h0, link_q};
          OFF_STATUS:     wb_dat_o <= {16'h0000, restarts_q, 1'b0, grp_alarm, 1'b0,
                                       svc_ok, temp_latch_q, perm};
          OFF_GRP_SEL:    wb_dat_o <= grp_sel_q;
          OFF_EVENT:      wb_dat_o <= {24'h00_0000, last_evt_q};
          default:        wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule : ssdu_top

// ---- include/ssdu_pkg.sv ----
// Package: register map, field positions, reset values and timing for the self-supervision unit
package ssdu_pkg;

  // ====================
  // Clock and timing
  // ====================
  localparam int unsigned CLK_HZ            = 50_000_000;  // System clock rate
  localparam int unsigned WDT_TIMEOUT_US    = 100_000;     // Heartbeat timeout
  localparam int unsigned WDT_TIMEOUT_CYC   = (CLK_HZ / 1_000_000) * WDT_TIMEOUT_US;
  localparam int unsigned RESTART_PULSE_US  = 10;          // Restart pulse length
  localparam int unsigned RESTART_PULSE_CYC = (CLK_HZ / 1_000_000) * RESTART_PULSE_US;
  localparam int unsigned MAX_RESTARTS      = 1;           // Restarts tried before giving up
  localparam int unsigned CNT_W             = 32;          // Width of timing counters

  // ====================
  // Sizes
  // ====================
  localparam int unsigned NUM_SRC    = 16;  // Alarm sources
  localparam int unsigned NUM_GROUPS = 3;   // Diagnostic alarm groups
  localparam int unsigned DIAG_W     = 16;  // Diagnostic word width
  localparam int unsigned NUM_DOUT   = 24;  // Digital output channels
  localparam int unsigned NUM_AUXOUT = 5;   // Further output channels
  localparam int unsigned NUM_SYS    = 10;  // System fault bits of word four

  // ====================
  // Register byte offsets
  // ====================
  localparam logic [7:0] OFF_DIAG_ONE   = 8'h00;  // diag_status_word_one
  localparam logic [7:0] OFF_DIAG_TWO   = 8'h04;  // diag_status_word_two
  localparam logic [7:0] OFF_DIAG_THREE = 8'h08;  // Third word, reads zero
  localparam logic [7:0] OFF_DIAG_FOUR  = 8'h0c;  // diag_status_word_four
  localparam logic [7:0] OFF_CTRL       = 8'h10;  // Group links and clear
  localparam logic [7:0] OFF_STATUS     = 8'h14;  // Unit state
  localparam logic [7:0] OFF_GRP_SEL    = 8'h18;  // Source-to-group map
  localparam logic [7:0] OFF_EVENT      = 8'h1c;  // Last event code

  // ====================
  // Control register fields
  // ====================
  localparam int unsigned CTRL_LINK_LSB = 0;  // Bits 2:0 link groups to service output
  localparam int unsigned CTRL_CLEAR    = 8;  // Write 1: clear latched diagnostic state
  localparam logic [2:0]  LINK_RESET    = 3'h2;  // Only group two linked

  // ====================
  // Status register fields
  // ====================
  localparam int unsigned ST_PERM    = 0;   // Permanent inoperative state
  localparam int unsigned ST_TEMP    = 1;   // Temporary inoperative latched
  localparam int unsigned ST_SVC     = 2;   // Service output level
  localparam int unsigned ST_GRP_LSB = 4;   // Bits 6:4 group alarms
  localparam int unsigned ST_RST_LSB = 8;   // Bits 15:8 restart count

  // ====================
  // Group select field: two bits per source
  // ====================
  localparam logic [1:0]  GRP_NONE      = 2'h0;
  localparam logic [1:0]  GRP_ONE       = 2'h1;
  localparam logic [1:0]  GRP_TWO       = 2'h2;
  localparam logic [1:0]  GRP_THREE     = 2'h3;
  localparam logic [31:0] GRP_SEL_RESET = 32'h5555_5555;  // All sources in group one

  // ====================
  // Event codes
  // ====================
  localparam logic [7:0] EVT_TEMP_ON  = 8'h38;  // Code 56
  localparam logic [7:0] EVT_TEMP_OFF = 8'h39;  // Code 57

  // Watchdog states
  typedef enum logic [1:0] {
    SSDU_RUN,
    SSDU_RESTART,
    SSDU_WAIT,
    SSDU_PERM
  } ssdu_wdt_t;

endpackage : ssdu_pkg

// ---- tb/ssdu_checker_assertions.sv ----
// Checker: port-level properties of the self-supervision unit
`timescale 1ns/100ps
module ssdu_checker
  import ssdu_pkg::*;
(
  input wire logic                         clk_i,
  input wire logic                         rst_i,
  input wire logic                         wb_cyc_i,
  input wire logic                         wb_stb_i,
  input wire logic                         wb_ack_o,
  input wire logic                         aux_supply_ok_i,
  input wire logic                         temp_fault_i,
  input wire logic                         password_open_i,
  input wire logic [ssdu_pkg::NUM_DOUT-1:0] dout_o,
  input wire logic                         service_fail_output_o,
  input wire logic                         status_led_o,
  input wire logic                         panel_fault_msg_o,
  input wire logic                         password_open_alarm_o,
  input wire logic                         event_valid_o,
  input wire logic [7:0]                   event_code_o,
  input wire logic                         mcu_restart_o
);
  // ====================
  // Properties, all in the one clock domain
  // ====================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_timing_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  perm_block_a: assert property (status_led_o && $past(status_led_o) |-> dout_o == '0)
    else $error("outputs not blocked");
  perm_release_a: assert property (status_led_o |-> !service_fail_output_o && panel_fault_msg_o)
    else $error("permanent state outputs wrong");
  supply_loss_a: assert property (!aux_supply_ok_i [*5] |-> !service_fail_output_o)
    else $error("service output kept without supply");
  event_on_a: assert property ($rose(temp_fault_i) ##1 temp_fault_i [*2] |=>
    event_valid_o && event_code_o == EVT_TEMP_ON) else $error("on event missing");
  event_off_a: assert property ($fell(temp_fault_i) ##1 !temp_fault_i [*2] |=>
    event_valid_o && event_code_o == EVT_TEMP_OFF) else $error("off event missing");
  event_pulse_a: assert property (event_valid_o |=> !event_valid_o)
    else $error("event longer than one cycle");
  password_alarm_a: assert property (password_open_i [*5] |-> password_open_alarm_o)
    else $error("password alarm missing");
  // Main scenarios reached
  restart_c: cover property (mcu_restart_o);
  perm_c: cover property (status_led_o);
  event_off_c: cover property (event_valid_o && event_code_o == EVT_TEMP_OFF);
endmodule : ssdu_checker

// ---- tb/ssdu_mcu_model.sv ----
// Model of the supervised controller: heartbeat while alive, revival on restart
`timescale 1ns/100ps
module ssdu_mcu_model (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic restart_i,   // Restart request from the watchdog
  input  wire logic hang_i,      // Bench command: program stalls
  input  wire logic heal_i,      // Bench choice: whether a restart revives the program
  output logic      heartbeat_o  // Toggles every fourth cycle while alive
);
  logic       alive_q;  // Program running
  logic [1:0] div_q;    // Heartbeat divider
  // Restart wins over a stall; a failed revival leaves the heartbeat frozen
  always_ff @(posedge clk_i) begin
    if (rst_i) alive_q <= 1'b1;
    else if (restart_i) alive_q <= heal_i;
    else if (hang_i) alive_q <= 1'b0;
  end
  // Heartbeat generation
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q       <= 2'h0;
      heartbeat_o <= 1'b0;
    end else if (alive_q) begin
      div_q <= div_q + 2'h1;
      if (div_q == 2'h3) heartbeat_o <= ~heartbeat_o;
    end
  end
endmodule : ssdu_mcu_model

// ---- tb/tb_self_supervision_diag_unit.sv ----
// Testbench: self-checking bench for the self-supervision unit
`timescale 1ns/100ps
module tb_self_supervision_diag_unit;
  import ssdu_pkg::*;
  // ====================
  // Signals
  // ====================
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, heartbeat_i, mcu_restart_o;
  logic [7:0]  wb_adr_i, event_code_o;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd, rnd;
  logic aux_supply_ok_i, temp_fault_i, panel_reset_i, password_open_i, hang, heal;
  logic rails_ok_i, boot_test_ok_i, main_func_ok_i;
  logic remote_link_up_i, ext_io_link_up_i, port_one_up_i, port_two_up_i;
  logic [NUM_SRC-1:0]    alarm_src_i;
  logic [NUM_DOUT-1:0]   dout_fault_i, dout_req_i, dout_o;
  logic [NUM_AUXOUT-1:0] auxout_fault_i;
  logic [NUM_SYS-1:0]    sys_fault_i;
  logic service_fail_output_o, status_led_o, panel_fault_msg_o, diag_matrix_sig_o;
  logic remote_link_alarm_o, ext_io_link_alarm_o, port_one_alarm_o, port_two_alarm_o;
  logic password_open_alarm_o, event_valid_o;
  logic [2:0] diag_group_o;
  int num_errors, checks, n;
  // Short counts keep the watchdog scenarios brief
  ssdu_top #(.WDT_CYCLES(50), .RESTART_CYCLES(4)) dut (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .heartbeat_i, .mcu_restart_o, .aux_supply_ok_i,
    .rails_ok_i, .boot_test_ok_i, .main_func_ok_i, .temp_fault_i,
    .panel_reset_i, .alarm_src_i, .dout_fault_i, .auxout_fault_i, .sys_fault_i,
    .remote_link_up_i, .ext_io_link_up_i, .port_one_up_i, .port_two_up_i,
    .password_open_i, .dout_req_i, .dout_o, .service_fail_output_o, .status_led_o,
    .panel_fault_msg_o, .diag_group_o, .diag_matrix_sig_o, .remote_link_alarm_o,
    .ext_io_link_alarm_o, .port_one_alarm_o, .port_two_alarm_o, .password_open_alarm_o,
    .event_valid_o, .event_code_o);
  ssdu_mcu_model mcu (.clk_i, .rst_i, .restart_i(mcu_restart_o), .hang_i(hang),
    .heal_i(heal), .heartbeat_o(heartbeat_i));
  // ====================
  // Helpers
  // ====================
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Expected diagnostic word; third word and unmapped places read zero
  function automatic logic [31:0] exp_word(input logic [7:0] a);
    case (a)
      OFF_DIAG_ONE: return {16'h0, dout_fault_i[8], auxout_fault_i, dout_fault_i[7:0], 2'b00};
      OFF_DIAG_TWO: return {17'h0, dout_fault_i[23:9]};
      OFF_DIAG_FOUR: return {22'h0, sys_fault_i};
      default: return 32'h0;
    endcase
  endfunction : exp_word
  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
  endtask : tick
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Classic single cycle; holds everything until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 50);
    if (k >= 50) chk(32'h0, 32'h1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task automatic results();
    $display("Errors %0d, checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  // ====================
  // Clock, watchdog and main sequence
  // ====================
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    #200000;
    num_errors++;
    results();
  end
  initial begin
    {rst_i, aux_supply_ok_i, heal, rails_ok_i, boot_test_ok_i, main_func_ok_i} = 6'h3f;
    rnd = 32'h91e4;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {temp_fault_i, panel_reset_i, password_open_i, hang, alarm_src_i, dout_req_i} = '0;
    {dout_fault_i, auxout_fault_i, sys_fault_i} = '0;
    {remote_link_up_i, ext_io_link_up_i, port_one_up_i, port_two_up_i} = 4'hf;
    {num_errors, checks} = '0;
    tick(20);
    rst_i <= 1'b0;
    tick(6);
    chk(service_fail_output_o, 1'b1);
    wb(1'b0, OFF_CTRL, 32'h0);
    chk(rd[2:0], LINK_RESET);
    wb(1'b0, OFF_GRP_SEL, 32'h0);
    chk(rd, GRP_SEL_RESET);
    wb(1'b0, 8'h24, 32'h0);
    chk(rd, 32'h0);
    // Random faults, links and requests; first pass drives every output and system fault input to ones
    for (int i = 0; i < 8; i++) begin
      repeat (7) rnd = lfsr(rnd);
      {dout_fault_i, auxout_fault_i, sys_fault_i} <= (i == 0) ? '1 : {rnd, rnd[6:0]};
      {remote_link_up_i, ext_io_link_up_i, port_one_up_i, port_two_up_i} <= rnd[4:1];
      password_open_i <= rnd[0];
      dout_req_i <= rnd[31:8];
      tick(6);
      chk({remote_link_alarm_o, ext_io_link_alarm_o, port_one_alarm_o, port_two_alarm_o,
           password_open_alarm_o}, {~rnd[4:1], rnd[0]});
      chk(dout_o, rnd[31:8]);
      for (int j = 0; j < 16; j += 4) begin
        wb(1'b1, j[7:0], rnd);
        wb(1'b0, j[7:0], 32'h0);
        chk(rd, exp_word(j[7:0]));
      end
    end
    // Source 0 to group three, source 1 stays in group one
    wb(1'b1, OFF_GRP_SEL, 32'h5555_5557);
    alarm_src_i <= 16'h0003;
    tick(6);
    chk(diag_group_o, 3'b101);
    chk(service_fail_output_o, 1'b1);
    wb(1'b1, OFF_CTRL, 32'h4);
    tick(6);
    chk(service_fail_output_o, 1'b0);
    wb(1'b1, OFF_GRP_SEL, 32'h5555_5556);
    tick(6);
    chk({diag_group_o, service_fail_output_o}, 4'b0111);
    alarm_src_i <= '0;
    wb(1'b1, OFF_CTRL, 32'h2);
    // Temporary fault: events, latch and panel clear
    temp_fault_i <= 1'b1;
    tick(6);
    chk({diag_matrix_sig_o, event_code_o}, {1'b1, EVT_TEMP_ON});
    temp_fault_i <= 1'b0;
    tick(6);
    chk(event_code_o, EVT_TEMP_OFF);
    wb(1'b0, OFF_STATUS, 32'h0);
    chk(rd[ST_TEMP], 1'b1);
    panel_reset_i <= 1'b1;
    tick(1);
    panel_reset_i <= 1'b0;
    tick(6);
    wb(1'b0, OFF_STATUS, 32'h0);
    chk({rd[ST_TEMP], diag_matrix_sig_o}, 2'b00);
    // Supply loss and return
    aux_supply_ok_i <= 1'b0;
    tick(6);
    chk(service_fail_output_o, 1'b0);
    aux_supply_ok_i <= 1'b1;
    rails_ok_i <= 1'b0;
    tick(6);
    chk(service_fail_output_o, 1'b0);
    rails_ok_i <= 1'b1;
    tick(6);
    chk(service_fail_output_o, 1'b1);
    // Stall that a restart cures, then one that it does not
    for (int r = 0; r < 2; r++) begin
      heal <= (r == 0);
      hang <= 1'b1;
      tick(1);
      hang <= 1'b0;
      dout_req_i <= '1;
      n = 0;
      while (mcu_restart_o !== 1'b1 && n < 200) begin
        tick(1);
        n++;
      end
      chk(mcu_restart_o, 1'b1);
      tick(200);
      chk({status_led_o, panel_fault_msg_o, service_fail_output_o}, (r == 0) ? 3'b001 : 3'b110);
    end
    chk(dout_o, '0);
    rst_i <= 1'b1;
    tick(3);
    rst_i <= 1'b0;
    tick(6);
    chk({status_led_o, service_fail_output_o}, 2'b01);
    results();
  end
endmodule : tb_self_supervision_diag_unit
bind ssdu_top ssdu_checker chk_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .aux_supply_ok_i, .temp_fault_i, .password_open_i, .dout_o, .service_fail_output_o,
  .status_led_o, .panel_fault_msg_o, .password_open_alarm_o, .event_valid_o,
  .event_code_o, .mcu_restart_o);
